// ==== inc/ssp_pkg.sv ====
// ssp_pkg: constants and carrier types for the synchronous serial port, spi mode
// assumes one 25 MHz system clock; no register bus, control bits arrive as ports
package ssp_pkg;

  localparam int unsigned SSP_CLK_HZ        = 25000000;
  localparam int unsigned SSP_BITS          = 8;
  localparam logic [3:0]  SSP_MODE_DIV4     = 4'h0;
  localparam logic [3:0]  SSP_MODE_DIV16    = 4'h1;
  localparam logic [3:0]  SSP_MODE_DIV64    = 4'h2;
  localparam logic [3:0]  SSP_MODE_TMR2     = 4'h3;
  localparam logic [3:0]  SSP_MODE_SLV_SS   = 4'h4;
  localparam logic [3:0]  SSP_MODE_SLV_NOSS = 4'h5;
  // half-period counts: fosc/4 gives a 2-cycle half period
  localparam logic [4:0]  SSP_HALF_DIV4     = 5'h01;
  localparam logic [4:0]  SSP_HALF_DIV16    = 5'h07;
  localparam logic [4:0]  SSP_HALF_DIV64    = 5'h1f;
  localparam logic [3:0]  SSP_CNT_RST       = 4'h0;
  localparam logic [7:0]  SSP_BYTE_RST      = 8'h00;

  typedef struct packed {
    logic       port_enable_bit;
    logic [3:0] port_mode_select;
    logic       clock_idle_polarity;
    logic       clock_edge_select;
    logic       input_sample_phase;
  } ssp_cfg_t;

  typedef struct packed {
    logic buffer_full_flag;
    logic port_interrupt_flag;
    logic write_collision_flag;
    logic receive_overflow_flag;
  } ssp_flags_t;

endpackage : ssp_pkg

// ==== src/ssp_rate_gen.sv ====
// ssp_rate_gen: half-bit enable pulse generator for master mode
// assumes tmr2_tick_i is a one-cycle pulse from the timer
`timescale 1ns/1ps
module ssp_rate_gen
  import ssp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run_i,
  input  wire logic [3:0] mode_i,
  input  wire logic       tmr2_tick_i,
  input  wire logic       hold_i,
  output logic            half_tick_o
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } ssp_rg_state_t;

  ssp_rg_state_t st_ff;
  ssp_rg_state_t nxt_st;
  logic [4:0]    limit;

  always_comb begin
    case (mode_i)
      SSP_MODE_DIV4:  limit = SSP_HALF_DIV4;
      SSP_MODE_DIV16: limit = SSP_HALF_DIV16;
      default:        limit = SSP_HALF_DIV64;
    endcase
  end

  // timer rate halves naturally: each timer pulse is one half period
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (!run_i) begin
      nxt_st.cnt = 5'h00;
    end else if (hold_i) begin
      // sleep keeps count and pending tick, so the bit time resumes exactly
      nxt_st.tick = st_ff.tick;
    end else if (mode_i == SSP_MODE_TMR2) begin
      nxt_st.tick = tmr2_tick_i;
    end else if (st_ff.cnt == limit) begin
      nxt_st.cnt  = 5'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign half_tick_o = st_ff.tick;

endmodule : ssp_rate_gen

// ==== src/ssp_spi_port.sv ====
// ssp_spi_port: spi mode of the synchronous serial port, master and slave
// assumes sck_i, sdi_i, ss_n_i are synchronous to clk_sys; buffer access is by strobes
//
// Summary of operation
// - each transfer shifts eight bits out and in together, msb first
// - only the master clocks; a slave never drives its own clock
// - after the eighth bit, byte goes to buffer, buffer-full and interrupt flags set
// - buffer write during a transfer is dropped and sets write collision until cleared
// - reading the buffer clears the buffer-full flag
// - shift register is reached only through the buffer register
// - enabled with a master mode, the port takes over data and clock pins
// - in master mode a buffer write starts a transfer at once
// - data-in is sampled on every clock even if data-out is unused
// - master clock is fosc/4, fosc/16, fosc/64 or timer output halved
// - polarity bit picks the idle clock level
// - with edge select set, data-out is valid before its sampling edge
// - sample phase bit picks middle or end of output bit time
// - in sleep a master transfer freezes and resumes on wake
// - slave shifts only on clock edges arriving on the clock pin
// - master may start at any moment and its clock drives the slave
// - mode 0100 is slave with select, 0101 slave without select
// - slave byte completing while buffer full sets overflow and is lost
// - with select control, high select resets bit counter and floats data-out
`timescale 1ns/1ps
module ssp_spi_port
  import ssp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  ssp_cfg_t        cfg_i,
  input  wire logic       sleep_i,
  input  wire logic       tmr2_tick_i,
  input  wire logic       buf_wr_i,
  input  wire logic [7:0] buf_wdata_i,
  input  wire logic       buf_rd_i,
  input  wire logic       write_collision_flag_clr_i,
  input  wire logic       ovf_clr_i,
  input  wire logic       irq_clr_i,
  input  wire logic       sck_i,
  input  wire logic       sdi_i,
  input  wire logic       ss_n_i,
  output logic [7:0]      buf_rdata_o,
  output ssp_flags_t      flags_o,
  output logic            busy_o,
  output logic            sck_o,
  output logic            sck_oe_n,
  output logic            sdo_o,
  output logic            sdo_oe_n
);

  typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_phase_t;

  typedef struct packed {
    ssp_phase_t phase;
    logic [7:0] shreg;
    logic [7:0] bufreg;
    logic [3:0] bitcnt;
    logic       samp;
    logic       sck_prev;
    ssp_flags_t flags;
    logic       sck;
    logic       sck_oe_n;
    logic       sdo;
    logic       sdo_oe_n;
    logic       busy;
    logic [4:0] sck_edges;
  } ssp_state_t;

  ssp_state_t st_ff;
  ssp_state_t nxt_st;
  logic       half_tick;
  logic       is_master;
  logic       is_slave;
  logic       ss_hold;
  logic       run_tick;
  logic       sck_lead;
  logic       sck_trail;
  logic       done;
  logic       wr_ok;

  assign is_master = cfg_i.port_enable_bit && (cfg_i.port_mode_select[3:2] == 2'b00);
  assign is_slave  = cfg_i.port_enable_bit &&
                     (cfg_i.port_mode_select == SSP_MODE_SLV_SS ||
                      cfg_i.port_mode_select == SSP_MODE_SLV_NOSS);
  assign ss_hold   = is_slave && (cfg_i.port_mode_select == SSP_MODE_SLV_SS) && ss_n_i;
  // sleep stops the divider so the master freezes mid-byte
  assign run_tick  = half_tick && !sleep_i;
  // slave edges relative to the idle level: leading leaves idle, trailing returns
  assign sck_lead  = (st_ff.sck_prev == cfg_i.clock_idle_polarity) &&
                     (sck_i != cfg_i.clock_idle_polarity);
  assign sck_trail = (st_ff.sck_prev != cfg_i.clock_idle_polarity) &&
                     (sck_i == cfg_i.clock_idle_polarity);
  assign wr_ok     = buf_wr_i && !st_ff.busy;

  ssp_rate_gen u_rate (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .run_i       (is_master && st_ff.busy),
    .mode_i      (cfg_i.port_mode_select),
    .tmr2_tick_i (tmr2_tick_i),
    .hold_i      (sleep_i),
    .half_tick_o (half_tick)
  );

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.sck_prev = sck_i;
    done            = 1'b0;

    if (!cfg_i.port_enable_bit || ss_hold) begin
      // disable or high select resets the bit engine
      nxt_st.phase  = SSP_IDLE;
      nxt_st.bitcnt = SSP_CNT_RST;
      nxt_st.busy   = 1'b0;
    end else if (is_master) begin
      if (st_ff.phase == SSP_IDLE) begin
        if (wr_ok) begin
          nxt_st.busy  = 1'b1;
          nxt_st.phase = SSP_LEAD;
        end
      end else if (run_tick) begin
        if (st_ff.phase == SSP_LEAD) begin
          // first half of bit time: middle sample point
          nxt_st.phase = SSP_TRAIL;
          if (!cfg_i.input_sample_phase) begin
            nxt_st.samp = sdi_i;
          end
        end else begin
          nxt_st.phase = SSP_LEAD;
          nxt_st.samp  = cfg_i.input_sample_phase ? sdi_i : st_ff.samp;
          nxt_st.shreg = {st_ff.shreg[6:0],
                          cfg_i.input_sample_phase ? sdi_i : st_ff.samp};
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          if (st_ff.bitcnt == 4'h7) begin
            nxt_st.phase = SSP_IDLE;
            nxt_st.busy  = 1'b0;
            done         = 1'b1;
          end
        end
      end
    end else if (is_slave) begin
      // slave never drives the clock, only follows edges
      if (wr_ok) begin
        nxt_st.shreg = buf_wdata_i;
      end
      if ((cfg_i.clock_edge_select && sck_trail) || (!cfg_i.clock_edge_select && sck_lead)) begin
        nxt_st.busy  = 1'b1;
        nxt_st.shreg = {st_ff.shreg[6:0], sdi_i};
        nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
        if (st_ff.bitcnt == 4'h7) begin
          nxt_st.bitcnt = SSP_CNT_RST;
          nxt_st.busy   = 1'b0;
          done          = 1'b1;
        end
      end
    end

    if (is_master && wr_ok && st_ff.phase == SSP_IDLE) begin
      nxt_st.shreg  = buf_wdata_i;
      nxt_st.bitcnt = SSP_CNT_RST;
    end

    // master clock: active level during trailing half when edge select set, else leading
    if (is_master) begin
      nxt_st.sck_oe_n = 1'b0;
      if (nxt_st.phase == SSP_IDLE) begin
        nxt_st.sck = cfg_i.clock_idle_polarity;
      end else begin
        nxt_st.sck = cfg_i.clock_idle_polarity ^
                     ((nxt_st.phase == SSP_TRAIL) ^ !cfg_i.clock_edge_select);
      end
    end else begin
      nxt_st.sck      = cfg_i.clock_idle_polarity;
      nxt_st.sck_oe_n = 1'b1;
    end
    // msb presented from the shift register ahead of its edge
    nxt_st.sdo      = nxt_st.shreg[7];
    nxt_st.sdo_oe_n = !(is_master || (is_slave && !ss_hold));

    // helper count of clock changes per byte, read only by the pulse-count check
    if (is_master && wr_ok && st_ff.phase == SSP_IDLE) begin
      nxt_st.sck_edges = 5'h00;
    end
    if (nxt_st.sck != st_ff.sck) begin
      nxt_st.sck_edges = nxt_st.sck_edges + 5'h01;
    end

    // flags: hardware set wins over software clear
    if (buf_rd_i) begin
      nxt_st.flags.buffer_full_flag = 1'b0;
    end
    if (irq_clr_i) begin
      nxt_st.flags.port_interrupt_flag = 1'b0;
    end
    if (write_collision_flag_clr_i) begin
      nxt_st.flags.write_collision_flag = 1'b0;
    end
    if (ovf_clr_i) begin
      nxt_st.flags.receive_overflow_flag = 1'b0;
    end
    if (buf_wr_i && st_ff.busy) begin
      nxt_st.flags.write_collision_flag = 1'b1;
    end
    if (done) begin
      if (is_slave && st_ff.flags.buffer_full_flag) begin
        nxt_st.flags.receive_overflow_flag = 1'b1;
      end else begin
        nxt_st.bufreg = nxt_st.shreg;
        nxt_st.flags.buffer_full_flag = 1'b1;
      end
      nxt_st.flags.port_interrupt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.phase    <= SSP_IDLE;
      st_ff.bufreg   <= SSP_BYTE_RST;
      st_ff.sck_oe_n <= 1'b1;
      st_ff.sdo_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign buf_rdata_o = st_ff.bufreg;
  assign flags_o     = st_ff.flags;
  assign busy_o      = st_ff.busy;
  assign sck_o       = st_ff.sck;
  assign sck_oe_n    = st_ff.sck_oe_n;
  assign sdo_o       = st_ff.sdo;
  assign sdo_oe_n    = st_ff.sdo_oe_n;

  a_write_collision_flag_set_on_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    buf_wr_i && busy_o && !write_collision_flag_clr_i && !done |=>
    flags_o.write_collision_flag && $stable(buf_rdata_o))
    else $error("write during transfer did not flag collision");
  a_full_clear_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    buf_rd_i && !done |=> !flags_o.buffer_full_flag)
    else $error("buffer read did not clear full flag");
  a_done_sets_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && !is_slave |=> flags_o.buffer_full_flag && flags_o.port_interrupt_flag)
    else $error("byte completion did not set flags");
  a_master_idle_sck: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_master && !busy_o && !buf_wr_i && $stable(cfg_i) |=> sck_o == cfg_i.clock_idle_polarity)
    else $error("master clock not at idle level");
  a_slave_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !is_master |=> sck_oe_n)
    else $error("slave drove the clock pin");
  a_ss_floats_sdo: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ss_hold |=> sdo_oe_n && !busy_o)
    else $error("high select did not float data out");
  a_master_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_master && buf_wr_i && !busy_o && !ss_hold |=> busy_o)
    else $error("buffer write did not start master transfer");
  a_sleep_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_master && busy_o && sleep_i && $stable(cfg_i) |=> $stable(st_ff.bitcnt))
    else $error("transfer advanced during sleep");
  a_ovf_slave: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && is_slave && flags_o.buffer_full_flag |=> flags_o.receive_overflow_flag)
    else $error("overflow not flagged");
  a_bitcnt_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.bitcnt <= 4'h8)
    else $error("bit counter passed eight");
  // pin hand-over, sticky flags, slave edge discipline and the clock count
  a_sck_pulse_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && is_master |=> st_ff.sck_edges == 5'h10)
    else $error("master byte did not give sixteen clock changes");
  a_sdo_msb_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_master && wr_ok |=> sdo_o == $past(buf_wdata_i[7]))
    else $error("msb not presented at transfer start");
  a_write_collision_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flags_o.write_collision_flag && !write_collision_flag_clr_i |=> flags_o.write_collision_flag)
    else $error("collision flag dropped without clear");
  a_no_master_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !is_slave && !flags_o.receive_overflow_flag |=> !flags_o.receive_overflow_flag)
    else $error("overflow set outside slave mode");
  a_slave_shift_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_slave && !ss_hold && !sck_lead && !sck_trail |=> $stable(st_ff.bitcnt))
    else $error("slave shifted without a clock edge");
  a_slave_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && is_slave |=> flags_o.port_interrupt_flag)
    else $error("slave byte did not set interrupt flag");
  a_master_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_master |=> !sck_oe_n && !sdo_oe_n)
    else $error("master did not take the pins");
  a_disable_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg_i.port_enable_bit |=> !busy_o && sdo_oe_n && sck_oe_n)
    else $error("disabled port still active");
  a_ss_clears_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ss_hold |=> st_ff.bitcnt == SSP_CNT_RST)
    else $error("high select did not clear bit counter");

  c_master_byte: cover property (@(posedge clk_sys) disable iff (!rst_n) done && is_master);
  c_slave_byte:  cover property (@(posedge clk_sys) disable iff (!rst_n) done && is_slave);
  c_collision:   cover property (@(posedge clk_sys) disable iff (!rst_n) buf_wr_i && busy_o);
  c_sleep_pause: cover property (@(posedge clk_sys) disable iff (!rst_n) busy_o && sleep_i);
  c_timer_byte:  cover property (@(posedge clk_sys) disable iff (!rst_n)
    done && cfg_i.port_mode_select == SSP_MODE_TMR2);

endmodule : ssp_spi_port

// ==== tb/ssp_slave_model.sv ====
// ssp_slave_model: behavioural spi slave facing the port in master mode
// assumes sck and mosi come from the port pins; sck stands still between frames
`timescale 1ns/1ps
module ssp_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       edge_sel,
  input  wire logic       sel_n,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx,
  output int              edges
);
  logic [7:0] sr;
  int         nout;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    edges = 0;
  end
  // own select line from the bench; a single slave on this link
  always @(posedge load) begin
    sr = tx;
    rx = 8'h00;
    nout = 0;
    edges = 0;
    if (edge_sel) begin
      miso = sr[7];
      nout = 1;
    end
  end
  // the slave only follows sck, it never makes a clock
  always @(sck) begin
    edges = edges + 1;
    if ((sck != cpol) ^ edge_sel) begin
      // released line shows the inverse, not the last bit
      if (nout < 8) miso <= #1 sr[7 - nout];
      else miso <= #1 ~miso;
      nout = nout + 1;
    end else begin
      rx = {rx[6:0], mosi};
    end
  end
  // deselect releases the line; it then inverts whatever the line shows
  always @(posedge sel_n) miso = ~miso;
endmodule : ssp_slave_model

// ==== tb/sync_serial_spi_port_tb.sv ====
// sync_serial_spi_port_tb: master and slave scenarios for the spi port
// assumes one 25 MHz clock; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module sync_serial_spi_port_tb
  import ssp_pkg::*;
;
  logic       clk_sys, rst_n, sleep, tick, wr, rd, wclr, oclr, iclr;
  logic       tsck, tsdi, ss_n, slv, ld, miso, sdi_w;
  logic       busy, sck_o, sck_oe_n, sdo_o, sdo_oe_n;
  logic [7:0] wdata, rdata, stx, srx;
  ssp_cfg_t   cfg;
  ssp_flags_t flags;
  int         errors, checked, edges;
  assign sdi_w = slv ? tsdi : miso;
  ssp_spi_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_i(cfg), .sleep_i(sleep),
    .tmr2_tick_i(tick), .buf_wr_i(wr), .buf_wdata_i(wdata), .buf_rd_i(rd),
    .write_collision_flag_clr_i(wclr), .ovf_clr_i(oclr), .irq_clr_i(iclr), .sck_i(tsck), .sdi_i(sdi_w),
    .ss_n_i(ss_n), .buf_rdata_o(rdata), .flags_o(flags), .busy_o(busy), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));
  ssp_slave_model peer (.sck(sck_o), .mosi(sdo_o), .cpol(cfg.clock_idle_polarity),
    .edge_sel(cfg.clock_edge_select), .sel_n(ss_n), .load(ld), .tx(stx), .miso(miso),
    .rx(srx), .edges(edges));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    tick = 1'b0;
    forever begin
      repeat (3) @(posedge clk_sys);
      #1 tick = 1'b1;
      @(posedge clk_sys);
      #1 tick = 1'b0;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic give_verdict();
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // disable, rewrite, re-enable: the only legal way to change the setup
  task automatic setup(input logic [3:0] md, input logic pol, input logic ck,
                       input logic sp);
    cfg.port_enable_bit = 1'b0;
    step(1);
    cfg = '{1'b0, md, pol, ck, sp};
    step(1);
    cfg.port_enable_bit = 1'b1;
    step(2);
  endtask : setup
  task automatic xfer(input logic [3:0] md, input logic pol, input logic ck,
                      input logic sp, input logic [7:0] d, input logic [7:0] s,
                      input int h, input bit nap);
    int n;
    int e;
    slv = 1'b0;
    stx = s;
    setup(md, pol, ck, sp);
    check(sck_o, pol);
    check({sck_oe_n, sdo_oe_n}, 2'b00);
    wdata = d;
    wr = 1'b1;
    ld = 1'b1;
    ss_n = 1'b0;
    step(1);
    wr = 1'b0;
    ld = 1'b0;
    step(1);
    check(busy, 1'b1);
    wdata = ~d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    n = 3;
    while (busy === 1'b1 && n < 4000) begin
      if (nap && n == 40) begin
        e = edges;
        sleep = 1'b1;
        step(60);
        check(edges, e);
        check(busy, 1'b1);
        sleep = 1'b0;
      end
      step(1);
      n++;
    end
    if (n >= 4000) begin
      errors++;
      give_verdict();
    end
    // deselect only after the end-of-bit sample point of the last bit
    ss_n = 1'b1;
    if (h > 0) check(n >= 16 * h && n <= 16 * h + 2, 1'b1);
    step(2);
    check(edges, 16);
    check(sck_o, pol);
    check(flags, 4'he);
    check(rdata, s);
    check(srx, d);
    rd = 1'b1;
    wclr = 1'b1;
    iclr = 1'b1;
    step(1);
    rd = 1'b0;
    wclr = 1'b0;
    iclr = 1'b0;
    step(1);
    check(flags, 4'h0);
  endtask : xfer
  task automatic shift_in(input logic [7:0] d, output logic [7:0] seen);
    for (int i = 7; i >= 0; i--) begin
      tsdi = d[i];
      seen[i] = sdo_o;
      step(3);
      tsck = 1'b1;
      step(4);
      tsck = 1'b0;
      step(3);
    end
    tsdi = ~tsdi;
    step(3);
  endtask : shift_in
  task automatic slave(input logic [3:0] md, input logic [7:0] t);
    logic [7:0] seen;
    slv = 1'b1;
    ss_n = 1'b1;
    setup(md, 1'b0, 1'b0, 1'b0);
    if (md == SSP_MODE_SLV_SS) begin
      check(sdo_oe_n, 1'b1);
      ss_n = 1'b0;
    end
    wdata = t;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(8);
    check(flags.buffer_full_flag, 1'b0);
    check(sck_oe_n, 1'b1);
    shift_in(8'h96, seen);
    check(seen, t);
    check(flags, 4'hc);
    check(rdata, 8'h96);
    iclr = 1'b1;
    step(1);
    iclr = 1'b0;
    shift_in(8'h3b, seen);
    check(flags, 4'hd);
    check(rdata, 8'h96);
    rd = 1'b1;
    oclr = 1'b1;
    iclr = 1'b1;
    step(1);
    rd = 1'b0;
    oclr = 1'b0;
    iclr = 1'b0;
    step(1);
    check(flags, 4'h0);
  endtask : slave
  initial begin
    {rst_n, sleep, wr, rd, wclr, oclr, iclr, tsck, tsdi, slv, ld} = '0;
    ss_n = 1'b1;
    wdata = 8'h00;
    stx = 8'h00;
    cfg = '0;
    errors = 0;
    checked = 0;
    step(8);
    check({sck_oe_n, sdo_oe_n, flags}, 6'h30);
    rst_n = 1'b1;
    step(1);
    xfer(SSP_MODE_DIV4, 1'b0, 1'b0, 1'b0, 8'ha5, 8'h3c, int'(SSP_HALF_DIV4) + 1, 1'b0);
    xfer(SSP_MODE_DIV16, 1'b1, 1'b1, 1'b1, 8'h81, 8'h7e, int'(SSP_HALF_DIV16) + 1, 1'b1);
    xfer(SSP_MODE_DIV64, 1'b0, 1'b1, 1'b0, 8'h5a, 8'hc3, int'(SSP_HALF_DIV64) + 1, 1'b0);
    xfer(SSP_MODE_TMR2, 1'b1, 1'b0, 1'b1, 8'h0f, 8'hf0, 0, 1'b0);
    slave(SSP_MODE_SLV_SS, 8'hc6);
    slave(SSP_MODE_SLV_NOSS, 8'h2d);
    give_verdict();
  end
endmodule : sync_serial_spi_port_tb
